/* File: pkg/i2c_host_regs.vh */
`ifndef I2C_HOST_REGS_VH
`define I2C_HOST_REGS_VH

// ----------------------------------------
// own registers, avalon word index
// ----------------------------------------
`define AV_CTRL        3'h0
`define AV_TARGET      3'h1
`define AV_COUNT       3'h2
`define AV_PRESCALE    3'h3
`define AV_CLKDIV      3'h4
`define AV_STATUS      3'h5
`define AV_RXDATA      3'h6

`define CTRL_GO_BIT    0
`define CTRL_RXRST_BIT 1

`define ST_BUSY_BIT    0
`define ST_DONE_BIT    1
`define ST_ARB_BIT     2
`define ST_STATE_LSB   8
`define ST_RXCNT_LSB   16

`define TARGET_RST     7'h00
`define COUNT_RST      8'h01
`define PRESCALE_RST   8'h00
`define CLKDIV_RST     16'h0005

// ----------------------------------------
// device register map
// ----------------------------------------
`define DEV_STR        4'h2
`define DEV_CLKL       4'h3
`define DEV_CLKH       4'h4
`define DEV_DRR        4'h6
`define DEV_SAR        4'h7
`define DEV_MDR        4'h9
`define DEV_IVR        4'hA
`define DEV_PSC        4'hC

// ----------------------------------------
// mode_control_reg fields, as masks
// ----------------------------------------
`define MDR_NACK_M     16'h8000
`define MDR_START_M    16'h2000
`define MDR_STOP_M     16'h0800
`define MDR_CTRL_M     16'h0400
`define MDR_TX_M       16'h0200
`define MDR_WIDE_M     16'h0100
`define MDR_REPEAT_M   16'h0080
`define MDR_LOOP_M     16'h0040
`define MDR_RUN_M      16'h0020
`define MDR_SBYTE_M    16'h0010
`define MDR_FREE_M     16'h0008
`define MDR_BC_8BIT    16'h0000

// ----------------------------------------
// irq_status_reg fields, bit positions
// ----------------------------------------
`define STR_ARB_BIT    0
`define STR_RRDY_BIT   3
`define STR_BUSY_BIT   12

`define ZERO16         16'h0000

`endif

/* File: hw/dev_access.v */
`timescale 1ns/1ps
// one register access on the device port; held until the device acks
module dev_access (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        go,
  input  wire        we,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  output reg         done,
  output reg  [15:0] rdata,
  output reg         dev_sel,
  output reg         dev_we,
  output reg  [3:0]  dev_addr,
  output reg  [15:0] dev_wdata,
  input  wire [15:0] dev_rdata,
  input  wire        dev_ack
);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      done      <= 1'b0;
      rdata     <= 16'h0000;
      dev_sel   <= 1'b0;
      dev_we    <= 1'b0;
      dev_addr  <= 4'h0;
      dev_wdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (go && !dev_sel) begin
        dev_sel   <= 1'b1;
        dev_we    <= we;
        dev_addr  <= addr;
        dev_wdata <= wdata;
      end else if (dev_sel && dev_ack) begin
        dev_sel <= 1'b0;
        dev_we  <= 1'b0;
        rdata   <= dev_rdata;
        done    <= 1'b1;
      end
    end
  end

endmodule

/* File: hw/i2c_rx_host.v */
`timescale 1ns/1ps
`include "i2c_host_regs.vh"

// Notes on behaviour
// RULE1: device as receiver answers unwanted bytes with NACK in the acknowledge slot.
// RULE2: force_nack_next set before the last bit's rising edge makes that byte NACK.
// RULE3: device answers the byte after an overrun with NACK.
// RULE4: clearing module_run means the device acknowledges nothing.
// RULE5: a stop request as master receiver NACKs the final byte before STOP.
// RULE6: with stop_request set the device counts bytes down and stops at zero.
// RULE7: setting stop_request from zero makes the device drive STOP.
// RULE8: low SDA beats high SDA; lowest bit stream wins, continuing over later bytes.
// RULE9: losing arbitration turns the device slave receiver and sets arb_lost_flag.
// RULE10: competing masters place repeated START or STOP at the same bit position.
// RULE11: clearing module_run resets every status bit until run is set again.
// RULE12: in software reset the device floats SDA and SCL.
// RULE13: never clear module_run in the middle of a transfer.
// RULE14: hardware reset restores all device registers; device idle until run is set.
// RULE15: keep module_run at zero while configuring the device.
// RULE16: order: clock, reset, configure, release, clear status, wait bus idle.
// RULE17: load target_addr_reg with the slave address before starting as master.
// RULE18: prescale so the module clock lies between 6.7 and 13.3 MHz.
// RULE19: write back status to clear it, then read irq_vector_reg until zero.
// RULE20: bit_count_field zero selects eight-bit words.
// RULE21: after bus_busy_flag reads zero, start_request sends START and address.
// RULE22: read rx_data_reg per rx_ready_flag, force NACK before last, then stop.
// RULE23: rx_ready_flag sets when a received byte lands in rx_data_reg.
// RULE24: a receiver whose shift register is full holds SCL low.
// RULE25: arb_lost_flag also sets on illegal START or STOP.
// RULE26: arbitration loss is a driven high read back low during SCL high.
module i2c_rx_host #(
  parameter DEPTH = 8,
  parameter IDX_W = 3
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [2:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output wire        dev_sel,
  output wire        dev_we,
  output wire [3:0]  dev_addr,
  output wire [15:0] dev_wdata,
  input  wire [15:0] dev_rdata,
  input  wire        dev_ack
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_IDLE   = 5'h00;
  localparam S_RST    = 5'h01;
  localparam S_SAR    = 5'h02;
  localparam S_PSC    = 5'h03;
  localparam S_CLKL   = 5'h04;
  localparam S_CLKH   = 5'h05;
  localparam S_CFG    = 5'h06;
  localparam S_RUN    = 5'h07;
  localparam S_STR_RD = 5'h08;
  localparam S_STR_WR = 5'h09;
  localparam S_IVR_RD = 5'h0A;
  localparam S_BB_RD  = 5'h0B;
  localparam S_START  = 5'h0C;
  localparam S_POLL   = 5'h0D;
  localparam S_DRR_RD = 5'h0E;
  localparam S_NACK   = 5'h0F;
  localparam S_STOP   = 5'h10;
  localparam S_DONE   = 5'h11;

  // ----------------------------------------
  // own registers
  // ----------------------------------------
  reg  [6:0]       target_q;
  reg  [7:0]       count_q;
  reg  [7:0]       prescale_q;
  reg  [15:0]      clk_low_q;
  reg  [15:0]      clk_high_q;
  reg              done_q;
  reg              arb_q;
  reg  [4:0]       state_q;
  reg              pend_q;
  reg              go_q;
  reg  [15:0]      str_q;
  reg  [7:0]       remain_q;
  reg  [7:0]       rx_mem_q [0:DEPTH-1];
  reg  [IDX_W-1:0] wr_idx_q;
  reg  [IDX_W-1:0] rd_idx_q;
  reg  [7:0]       rx_cnt_q;
  reg              acc_we;
  reg  [3:0]       acc_addr;
  reg  [15:0]      acc_wdata;
  wire             acc_done;
  wire [15:0]      acc_rdata;
  wire             wr_hit;
  wire             rd_hit;
  wire             start_go;
  wire [15:0]      cfg_w;
  wire             busy;
  integer          i;

  assign wr_hit   = avs_write && !avs_waitrequest;
  assign rd_hit   = avs_read && !avs_waitrequest;
  assign start_go = wr_hit && (avs_address == `AV_CTRL) && avs_writedata[`CTRL_GO_BIT] && (state_q == S_IDLE);
  assign busy     = (state_q != S_IDLE);

  // master receiver, 7-bit address, no repeat, loopback, free format or start byte
  // repeat mode stays off, so no repeated START ever meets a rival master mid-arbitration
  assign cfg_w = `MDR_CTRL_M | `MDR_BC_8BIT; // see RULE10, RULE20

  // ----------------------------------------
  // avalon slave: one wait state per access
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      target_q        <= `TARGET_RST;
      count_q         <= `COUNT_RST;
      prescale_q      <= `PRESCALE_RST;
      clk_low_q       <= `CLKDIV_RST;
      clk_high_q      <= `CLKDIV_RST;
      rd_idx_q        <= {IDX_W{1'b0}};
    end else begin
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= 32'h00000000;
        if (avs_read) begin
          case (avs_address)
            `AV_TARGET:   avs_readdata <= {25'h0000000, target_q};
            `AV_COUNT:    avs_readdata <= {24'h000000, count_q};
            `AV_PRESCALE: avs_readdata <= {24'h000000, prescale_q};
            `AV_CLKDIV:   avs_readdata <= {clk_high_q, clk_low_q};
            `AV_STATUS:   avs_readdata <= {8'h00, rx_cnt_q, 3'h0, state_q, 5'h00, arb_q, done_q, busy};
            `AV_RXDATA:   avs_readdata <= {24'h000000, rx_mem_q[rd_idx_q]};
            default:      avs_readdata <= 32'h00000000;
          endcase
        end
      end
      // settings are frozen while a transfer runs
      if (wr_hit && !busy) begin
        case (avs_address)
          `AV_TARGET:   target_q   <= avs_writedata[6:0];
          `AV_COUNT:    count_q    <= avs_writedata[7:0];
          `AV_PRESCALE: prescale_q <= avs_writedata[7:0];
          `AV_CLKDIV: begin
            clk_low_q  <= avs_writedata[15:0];
            clk_high_q <= avs_writedata[31:16];
          end
          default: ;
        endcase
      end
      if (wr_hit && (avs_address == `AV_CTRL) && avs_writedata[`CTRL_RXRST_BIT])
        rd_idx_q <= {IDX_W{1'b0}};
      else if (rd_hit && (avs_address == `AV_RXDATA))
        rd_idx_q <= rd_idx_q + {{(IDX_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // access request for the current state
  // ----------------------------------------
  always @* begin
    acc_we    = 1'b1;
    acc_addr  = `DEV_MDR;
    acc_wdata = `ZERO16;
    case (state_q)
      S_RST:    acc_wdata = `ZERO16;                      // see RULE15
      S_SAR:    begin
        acc_addr  = `DEV_SAR;
        acc_wdata = {9'h000, target_q};                   // see RULE17
      end
      S_PSC:    begin
        acc_addr  = `DEV_PSC;
        acc_wdata = {8'h00, prescale_q};                  // see RULE18
      end
      S_CLKL:   begin
        acc_addr  = `DEV_CLKL;
        acc_wdata = clk_low_q;
      end
      S_CLKH:   begin
        acc_addr  = `DEV_CLKH;
        acc_wdata = clk_high_q;
      end
      S_CFG:    acc_wdata = cfg_w;
      S_RUN:    acc_wdata = cfg_w | `MDR_RUN_M;
      S_STR_RD: begin
        acc_we   = 1'b0;
        acc_addr = `DEV_STR;
      end
      S_STR_WR: begin
        acc_addr  = `DEV_STR;
        acc_wdata = str_q;                                // see RULE19
      end
      S_IVR_RD: begin
        acc_we   = 1'b0;
        acc_addr = `DEV_IVR;
      end
      S_BB_RD, S_POLL: begin
        acc_we   = 1'b0;
        acc_addr = `DEV_STR;
      end
      S_START:  begin
        // a one-byte read needs its NACK armed before the start
        if (remain_q == 8'h01)
          acc_wdata = cfg_w | `MDR_RUN_M | `MDR_START_M | `MDR_NACK_M; // see RULE2
        else
          acc_wdata = cfg_w | `MDR_RUN_M | `MDR_START_M;  // see RULE21
      end
      S_DRR_RD: begin
        acc_we   = 1'b0;
        acc_addr = `DEV_DRR;
      end
      S_NACK:   acc_wdata = cfg_w | `MDR_RUN_M | `MDR_NACK_M; // see RULE22
      S_STOP:   acc_wdata = cfg_w | `MDR_RUN_M | `MDR_STOP_M; // see RULE7
      default:  acc_we = 1'b0;
    endcase
  end

  // ----------------------------------------
  // bring-up and receive sequence
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q  <= S_IDLE;
      pend_q   <= 1'b0;
      go_q     <= 1'b0;
      str_q    <= `ZERO16;
      remain_q <= 8'h00;
      done_q   <= 1'b0;
      arb_q    <= 1'b0;
      wr_idx_q <= {IDX_W{1'b0}};
      rx_cnt_q <= 8'h00;
      for (i = 0; i < DEPTH; i = i + 1)
        rx_mem_q[i] <= 8'h00;
    end else begin
      go_q <= 1'b0;
      if (state_q != S_IDLE && state_q != S_DONE && !pend_q) begin
        go_q   <= 1'b1;
        pend_q <= 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          if (start_go) begin
            done_q   <= 1'b0;
            arb_q    <= 1'b0;
            rx_cnt_q <= 8'h00;
            wr_idx_q <= {IDX_W{1'b0}};
            // a zero count still reads one byte
            remain_q <= (count_q == 8'h00) ? 8'h01 : count_q;
            state_q  <= S_RST;                            // see RULE16
          end
        end
        S_DONE: begin
          done_q  <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          if (pend_q && acc_done) begin
            pend_q <= 1'b0;
            case (state_q)
              S_RST:    state_q <= S_SAR;
              S_SAR:    state_q <= S_PSC;
              S_PSC:    state_q <= S_CLKL;
              S_CLKL:   state_q <= S_CLKH;
              S_CLKH:   state_q <= S_CFG;
              S_CFG:    state_q <= S_RUN;
              S_RUN:    state_q <= S_STR_RD;
              S_STR_RD: begin
                str_q   <= acc_rdata;
                state_q <= S_STR_WR;
              end
              S_STR_WR: state_q <= S_IVR_RD;
              S_IVR_RD: begin
                if (acc_rdata == `ZERO16)
                  state_q <= S_BB_RD;                     // see RULE19
              end
              S_BB_RD: begin
                if (!acc_rdata[`STR_BUSY_BIT])
                  state_q <= S_START;                     // see RULE21
              end
              S_START:  state_q <= S_POLL;
              S_POLL: begin
                // on a lost arbitration the device is slave now; run stays set
                if (acc_rdata[`STR_ARB_BIT]) begin
                  arb_q   <= 1'b1;                        // see RULE9
                  state_q <= S_DONE;                      // see RULE13
                end else if (acc_rdata[`STR_RRDY_BIT])
                  state_q <= S_DRR_RD;                    // see RULE23
              end
              S_DRR_RD: begin
                rx_mem_q[wr_idx_q] <= acc_rdata[7:0];
                wr_idx_q <= wr_idx_q + {{(IDX_W-1){1'b0}}, 1'b1};
                rx_cnt_q <= rx_cnt_q + 8'h01;
                remain_q <= remain_q - 8'h01;
                if (remain_q == 8'h01)
                  state_q <= S_STOP;                      // see RULE22
                else if (remain_q == 8'h02)
                  state_q <= S_NACK;                      // see RULE2
                else
                  state_q <= S_POLL;
              end
              S_NACK:   state_q <= S_POLL;
              S_STOP:   state_q <= S_DONE;                // see RULE13
              default:  state_q <= S_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // device register port
  // ----------------------------------------
  dev_access u_access (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .go        (go_q),
    .we        (acc_we),
    .addr      (acc_addr),
    .wdata     (acc_wdata),
    .done      (acc_done),
    .rdata     (acc_rdata),
    .dev_sel   (dev_sel),
    .dev_we    (dev_we),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_rdata (dev_rdata),
    .dev_ack   (dev_ack)
  );

endmodule

/* File: sim/i2c_rx_host_props.sv */
`timescale 1ns/1ps
`include "i2c_host_regs.vh"
module i2c_rx_host_props #(
  parameter DEPTH = 8,
  parameter IDX_W = 3
) (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [2:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        dev_sel,
  input wire        dev_we,
  input wire [3:0]  dev_addr,
  input wire [15:0] dev_wdata,
  input wire [15:0] dev_rdata,
  input wire        dev_ack
);
  // ----------------------------------------
  // device port bookkeeping
  // ----------------------------------------
  wire wr_ack   = dev_sel && dev_we && dev_ack;
  wire rd_ack   = dev_sel && !dev_we && dev_ack;
  wire mdr_wr   = wr_ack && dev_addr == `DEV_MDR;
  wire start_wr = mdr_wr && dev_wdata[13];
  wire cfg_wr   = wr_ack && (dev_addr == `DEV_SAR || dev_addr == `DEV_PSC || dev_addr == `DEV_CLKL
                  || dev_addr == `DEV_CLKH);
  reg  run_q, sar_q, busy_q, ivr_q, nack_q, arb_q;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      run_q  <= 1'b0;
      sar_q  <= 1'b0;
      busy_q <= 1'b1;
      ivr_q  <= 1'b0;
      nack_q <= 1'b0;
      arb_q  <= 1'b0;
    end else begin
      if (mdr_wr) begin
        run_q <= dev_wdata[5];
        // only a run-to-reset write wipes the record; configuring with run low keeps it
        if (!dev_wdata[5] && run_q) begin
          sar_q  <= 1'b0;
          ivr_q  <= 1'b0;
          nack_q <= 1'b0;
        end else if (dev_wdata[15]) begin
          nack_q <= 1'b1;
        end
      end
      if (wr_ack && dev_addr == `DEV_SAR) sar_q <= 1'b1;
      if (rd_ack && dev_addr == `DEV_IVR) ivr_q <= dev_rdata == 16'h0000;
      if (rd_ack && dev_addr == `DEV_STR) busy_q <= dev_rdata[12];
      // a new go is the only thing that lets traffic resume after a lost arbitration
      if (avs_write && avs_waitrequest && avs_address == `AV_CTRL && avs_writedata[0]) arb_q <= 1'b0;
      else if (rd_ack && dev_addr == `DEV_STR && dev_rdata[0]) arb_q <= 1'b1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_cfg_stopped: assert property (cfg_wr |-> !run_q)
    else $error("device configured while running");
  chk_addr_first: assert property (start_wr |-> sar_q)
    else $error("start before target address loaded");
  chk_idle_start: assert property (start_wr |-> !busy_q)
    else $error("start without idle bus seen");
  chk_status_clear: assert property (start_wr |-> ivr_q)
    else $error("start before vector drained");
  chk_arb_halt: assert property (dev_sel && dev_we |-> !arb_q)
    else $error("device written after lost arbitration");
  chk_nack_stop: assert property (mdr_wr && dev_wdata[11] |-> nack_q)
    else $error("stop without nack armed");
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not a one cycle pulse");
  chk_sel_hold: assert property (dev_sel && !dev_ack |=> dev_sel && $stable(dev_addr) && $stable(dev_wdata)
    && $stable(dev_we))
    else $error("device request changed before ack");
  chk_sel_drop: assert property (dev_sel && dev_ack |=> !dev_sel [*2])
    else $error("device request gap too short");

  cover property (start_wr);
  cover property (mdr_wr && dev_wdata[11]);
  cover property (arb_q);
  cover property (dev_sel && !dev_ack [*3]);
endmodule

bind i2c_rx_host i2c_rx_host_props #(.DEPTH(DEPTH), .IDX_W(IDX_W)) props (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dev_sel(dev_sel), .dev_we(dev_we),
  .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack));

/* File: sim/dev_model.sv */
`timescale 1ns/1ps
`include "i2c_host_regs.vh"
module dev_model (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        dev_sel,
  input  wire        dev_we,
  input  wire [3:0]  dev_addr,
  input  wire [15:0] dev_wdata,
  output reg  [15:0] dev_rdata,
  output reg         dev_ack,
  input  wire        slow,
  input  wire        lose_arb
);
  // ----------------------------------------
  // behavioural device, bytes come from a slave
  // ----------------------------------------
  reg [15:0] mdr_q, sar_q, psc_q, clkl_q, clkh_q, str_q;
  reg [7:0]  bytes_out, nack_at, rx_wait;
  reg [2:0]  cnt;
  reg [1:0]  ivr_n, bb_n;
  reg        active, stopped, order_err;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      // every register back to default, idle until run is set
      {mdr_q, sar_q, psc_q, clkl_q, clkh_q, str_q} <= {6{16'h0000}};
      {bytes_out, rx_wait, cnt, active, stopped, order_err, dev_ack} <= 23'h000000;
      {ivr_n, bb_n, nack_at, dev_rdata} <= {4'hA, 8'hFF, 16'hFFFF};
    end else begin
      dev_ack <= 1'b0;
      if (dev_ack) dev_rdata <= ~dev_rdata;
      // full receive register stalls the clock, so no overrun and no NACK after an overrun
      if (active && !str_q[3]) begin
        if (rx_wait != 8'h00) rx_wait <= rx_wait - 8'h01;
        else begin
          str_q[3]  <= 1'b1;
          bytes_out <= bytes_out + 8'h01;
          if (nack_at != 8'hFF) active <= 1'b0;
        end
      end
      if (dev_sel && !dev_ack) begin
        if (cnt != (slow ? 3'h4 : 3'h0)) cnt <= cnt + 3'h1;
        else begin
          cnt     <= 3'h0;
          dev_ack <= 1'b1;
          if (dev_we && mdr_q[5] && dev_addr != `DEV_MDR && dev_addr != `DEV_STR) order_err <= 1'b1;
          if (dev_we) begin
            case (dev_addr)
              `DEV_MDR: begin
                mdr_q <= dev_wdata;
                if (!dev_wdata[5]) begin
                  // lines floated, status defaulted, nothing acknowledged
                  {str_q, bytes_out, active, stopped} <= 26'h0000000;
                  {ivr_n, bb_n, nack_at} <= 12'hAFF;
                end else begin
                  if (dev_wdata[15] && nack_at == 8'hFF) nack_at <= bytes_out;
                  if (dev_wdata[13] && !lose_arb) {active, rx_wait} <= 9'h128;
                  if (dev_wdata[13] && lose_arb) str_q[0] <= 1'b1;
                  if (dev_wdata[11]) {active, stopped} <= 2'b01;
                end
              end
              `DEV_STR:  str_q <= str_q & ~dev_wdata;
              `DEV_SAR:  sar_q <= dev_wdata;
              `DEV_PSC:  psc_q <= dev_wdata;
              `DEV_CLKL: clkl_q <= dev_wdata;
              `DEV_CLKH: clkh_q <= dev_wdata;
              default:   ;
            endcase
          end else begin
            case (dev_addr)
              `DEV_STR: begin
                dev_rdata <= str_q | {3'b000, bb_n != 2'b00, 12'h000};
                if (bb_n != 2'b00) bb_n <= bb_n - 2'b01;
              end
              `DEV_IVR: begin
                dev_rdata <= {14'h0000, ivr_n};
                if (ivr_n != 2'b00) ivr_n <= ivr_n - 2'b01;
              end
              `DEV_DRR: begin
                dev_rdata <= {8'h5C, 8'hA0 | bytes_out};
                str_q[3]  <= 1'b0;
                rx_wait   <= 8'h28;
              end
              default:  dev_rdata <= mdr_q;
            endcase
          end
        end
      end
    end
  end
endmodule

/* File: sim/i2c_rx_host_test.sv */
`timescale 1ns/1ps
`include "i2c_host_regs.vh"
module i2c_rx_host_test;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [2:0]  avs_address = 3'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h00000000;
  reg         slow = 1'b0;
  reg         lose_arb = 1'b0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, dev_sel, dev_we, dev_ack;
  wire [3:0]  dev_addr;
  wire [15:0] dev_wdata, dev_rdata;
  reg  [31:0] rd;
  integer     fails = 0;
  integer     n_checks = 0;
  integer     i;

  always #50 ref_clk = ~ref_clk;

  i2c_rx_host uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dev_sel(dev_sel), .dev_we(dev_we), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack));
  dev_model m (.ref_clk(ref_clk), .rst_n(rst_n), .dev_sel(dev_sel), .dev_we(dev_we), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack), .slow(slow), .lose_arb(lose_arb));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask

  // avalon access: held until waitrequest is seen low at an edge
  task av(input w, input [2:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge ref_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      k = 0;
      do begin
        @(posedge ref_clk);
        k = k + 1;
      end while (avs_waitrequest !== 1'b0 && k < 200);
      if (k >= 200) fails = fails + 1;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
    end
  endtask

  // one receive run; the target write after go must be ignored while busy
  task xfer(input [7:0] n, input sl, input la);
    integer k;
    begin
      slow     <= sl;
      lose_arb <= la;
      av(1'b1, `AV_COUNT, {24'h000000, n});
      av(1'b1, `AV_CTRL, 32'h00000001);
      av(1'b1, `AV_TARGET, 32'h00000011);
      k = 0;
      do begin
        av(1'b0, `AV_STATUS, 32'h00000000);
        k = k + 1;
      end while (rd[1] !== 1'b1 && k < 1000);
      check(rd[2:0], la ? 3'h6 : 3'h2);
      check(m.bytes_out, la ? 8'h00 : n);
      check(m.nack_at, la ? 8'hFF : n - 8'h01);
      check(m.stopped, !la);
      check(m.mdr_q, la ? 16'h2420 : 16'h0C20);
      check(m.sar_q, 16'h005A);
      check(m.order_err, 1'b0);
      $display("test transfer of %0d done", n);
    end
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      if (i < 5 || i == 7) begin
        av(1'b0, i[2:0], 32'h00000000);
        check(rd, (i == 2) ? 32'h00000001 : (i == 4) ? 32'h00050005 : 32'h00000000);
      end
    end
    av(1'b0, `AV_STATUS, 32'h00000000);
    check(rd[2:0], 3'h0);
    $display("test reset values done");
    av(1'b1, `AV_TARGET, 32'h0000005A);
    av(1'b1, `AV_PRESCALE, 32'h0000000B);
    av(1'b1, `AV_CLKDIV, 32'h00090007);
    xfer(8'h03, 1'b0, 1'b0);
    check(rd[23:16], 8'h03);
    check({m.psc_q, m.clkl_q, m.clkh_q}, {16'h000B, 16'h0007, 16'h0009});
    av(1'b1, `AV_CTRL, 32'h00000002);
    for (i = 0; i < 3; i = i + 1) begin
      av(1'b0, `AV_RXDATA, 32'h00000000);
      check(rd[7:0], 8'hA1 + i[7:0]);
    end
    xfer(8'h01, 1'b1, 1'b0);
    xfer(8'h02, 1'b0, 1'b1);
    xfer(8'h02, 1'b1, 1'b0);
    av(1'b1, `AV_CTRL, 32'h00000001);
    repeat (30) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check({dev_sel, avs_waitrequest}, 2'h1);
    rst_n <= 1'b1;
    av(1'b0, `AV_TARGET, 32'h00000000);
    check(rd, 32'h00000000);
    $display("test reset mid run done");
    stop_test;
  end

  initial begin
    #3000000;
    fails = fails + 1;
    stop_test;
  end
endmodule
